// File: lsp_params.svh
// Offsets, field positions, reset values for the lane-select and PLL control bank
`ifndef LSP_PARAMS_SVH
`define LSP_PARAMS_SVH

// Register addresses within the management device space
`define LSP_ADDR_CTRL        16'h0006
`define LSP_ADDR_LANE_B      16'h0007
`define LSP_ADDR_LANE_C      16'h0008
`define LSP_ADDR_LANE_CH     16'h0010

// Field positions of the control register
`define LSP_MASK_MSB         15
`define LSP_MASK_LSB         12
`define LSP_RSVH_MSB         11
`define LSP_RSVH_LSB         10
`define LSP_BW_MSB           9
`define LSP_BW_LSB           8
`define LSP_RSVL_MSB         7
`define LSP_RSVL_LSB         5
`define LSP_PLLON_BIT        4
`define LSP_MPY_MSB          3
`define LSP_MPY_LSB          0

// Reset values
`define LSP_RST_MASK         4'hF
`define LSP_RST_RSVH         2'h0
`define LSP_RST_BW           2'h1
`define LSP_RST_RSVL         3'h0
`define LSP_RST_PLLON        1'h1
`define LSP_RST_MPY          4'h5
`define LSP_RST_LANE_B       16'hDC04
`define LSP_RST_LANE_C       16'h0000
`define LSP_RST_LANE_CH      16'h0000
`define LSP_RDATA_NONE       16'h0000

// Loop bandwidth codes
`define LSP_BW_NO_CLEANER    2'h1
`define LSP_BW_CLEANER       2'h2

`endif

// File: lsp_pkg.sv
// Types for the lane-select and PLL control bank
`default_nettype none
package lsp_pkg;

    typedef struct packed {
        logic [3:0] lane_select_mask;
        logic [1:0] rsv_hi;
        logic [1:0] pll_loop_bw_sel;
        logic [2:0] rsv_lo;
        logic       pll_on;
        logic [3:0] pll_multiplier;
    } lsp_ctrl_t;

    typedef logic [3:0][15:0] lsp_lanes_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } lsp_req_t;

    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } lsp_rsp_t;

    typedef struct packed {
        lsp_ctrl_t  ctrl;
        lsp_lanes_t lane_b;
        lsp_lanes_t lane_c;
        lsp_lanes_t lane_ch;
        logic       pd_meta;
        logic       pd_sync;
        logic       pll_run;
        lsp_rsp_t   rsp;
    } lsp_state_t;

endpackage
`default_nettype wire

// File: lsp_lane_pll_ctrl.sv
// Lane selection mask and low-speed PLL control register with per-lane settings
//
// How it works
// - The top nibble is a lane mask, bit n for lane n, reset to all lanes selected.
// - A write to a lane setting register updates only the lanes whose mask bit is one.
// - A read of a lane setting register returns the lane chosen by a one-hot mask.
// - Loop bandwidth resets to 01, 10 is used with a jitter cleaner, 00 and 11 are unused.
// - The PLL is off while the channel power-down pin is low or global power-down is set.
// - Bit 4 turns the PLL on when one and off when zero, resetting to one.
// - The low four bits hold the PLL multiplier code, resetting to 0101.
// - Bits 11:10 are read/write spare bits resetting to 00.
// - Bits 7:5 are read/write spare bits resetting to 000.
// - Multiplier codes are stored and driven out as written, reserved codes included.
`include "lsp_params.svh"
`default_nettype none

module lsp_lane_pll_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Management register access
    input wire lsp_pkg::lsp_req_t mgmt_req,
    output var lsp_pkg::lsp_rsp_t mgmt_rsp,
    // Power-down sources
    input wire logic channel_powerdown_n,
    input wire logic global_powerdown,
    // PLL and lane controls
    output var logic pll_run,
    output var logic [1:0] pll_loop_bw_sel,
    output var logic [3:0] pll_multiplier,
    output var lsp_pkg::lsp_lanes_t lane_ctrl_b,
    output var lsp_pkg::lsp_lanes_t lane_ctrl_c,
    output var lsp_pkg::lsp_lanes_t lane_channel_ctrl
);

    localparam lsp_pkg::lsp_ctrl_t CTRL_RST = '{
        lane_select_mask: `LSP_RST_MASK,
        rsv_hi: `LSP_RST_RSVH,
        pll_loop_bw_sel: `LSP_RST_BW,
        rsv_lo: `LSP_RST_RSVL,
        pll_on: `LSP_RST_PLLON,
        pll_multiplier: `LSP_RST_MPY
    };

    localparam lsp_pkg::lsp_state_t ST_RST = '{
        ctrl: CTRL_RST,
        lane_b: {4{`LSP_RST_LANE_B}},
        lane_c: {4{`LSP_RST_LANE_C}},
        lane_ch: {4{`LSP_RST_LANE_CH}},
        pd_meta: 1'h0,
        pd_sync: 1'h0,
        pll_run: 1'h0,
        rsp: '{rvalid: 1'h0, rdata: `LSP_RDATA_NONE}
    };

    lsp_pkg::lsp_state_t st;
    lsp_pkg::lsp_state_t next_st;

    // Lane picked by a one-hot mask; valid low otherwise
    function automatic logic [2:0] onehot_lane(input logic [3:0] mask);
        logic [2:0] res;
        res = 3'h0;
        case (mask)
            4'h1: res = 3'h4;
            4'h2: res = 3'h5;
            4'h4: res = 3'h6;
            4'h8: res = 3'h7;
            default: res = 3'h0;
        endcase
        return res;
    endfunction

    // Merge a write into every masked lane
    function automatic lsp_pkg::lsp_lanes_t lane_write(input lsp_pkg::lsp_lanes_t cur,
                                                       input logic [3:0] mask,
                                                       input logic [15:0] data);
        lsp_pkg::lsp_lanes_t res;
        res = cur;
        for (int i = 0; i < 4; i++) begin
            if (mask[i]) begin
                res[i] = data;
            end
        end
        return res;
    endfunction

    // Which register an address names, one bit each; unmapped hits nothing
    function automatic logic [3:0] reg_hit(input logic [15:0] addr);
        logic [3:0] res;
        res = 4'h0;
        case (addr)
            `LSP_ADDR_CTRL: res = 4'h1;
            `LSP_ADDR_LANE_B: res = 4'h2;
            `LSP_ADDR_LANE_C: res = 4'h4;
            `LSP_ADDR_LANE_CH: res = 4'h8;
            default: res = 4'h0;
        endcase
        return res;
    endfunction

    // Word of the picked lane, empty answer when no single lane is picked
    function automatic logic [15:0] lane_read(input lsp_pkg::lsp_lanes_t cur,
                                              input logic [2:0] pick);
        logic [15:0] res;
        res = `LSP_RDATA_NONE;
        if (pick[2]) begin
            res = cur[pick[1:0]];
        end
        return res;
    endfunction

    // Control word split into its fields; reserved codes kept as written
    function automatic lsp_pkg::lsp_ctrl_t ctrl_write(input logic [15:0] data);
        lsp_pkg::lsp_ctrl_t res;
        res.lane_select_mask = data[`LSP_MASK_MSB:`LSP_MASK_LSB];
        res.rsv_hi = data[`LSP_RSVH_MSB:`LSP_RSVH_LSB];
        res.pll_loop_bw_sel = data[`LSP_BW_MSB:`LSP_BW_LSB];
        res.rsv_lo = data[`LSP_RSVL_MSB:`LSP_RSVL_LSB];
        res.pll_on = data[`LSP_PLLON_BIT];
        res.pll_multiplier = data[`LSP_MPY_MSB:`LSP_MPY_LSB];
        return res;
    endfunction

    logic [2:0] sel;
    logic [3:0] mask;
    logic [3:0] wr_hit;
    logic [3:0] rd_hit;

    always_comb begin
        next_st = st;
        mask = st.ctrl.lane_select_mask;
        sel = onehot_lane(mask);
        wr_hit = mgmt_req.wr ? reg_hit(mgmt_req.addr) : 4'h0;
        rd_hit = mgmt_req.rd ? reg_hit(mgmt_req.addr) : 4'h0;
        // Power-down pin passes two flops before use
        next_st.pd_meta = channel_powerdown_n;
        next_st.pd_sync = st.pd_meta;
        next_st.pll_run = st.ctrl.pll_on & st.pd_sync & ~global_powerdown;
        // Writes take effect at the next edge
        if (wr_hit[0]) begin
            next_st.ctrl = ctrl_write(mgmt_req.wdata);
        end
        if (wr_hit[1]) begin
            next_st.lane_b = lane_write(st.lane_b, mask, mgmt_req.wdata);
        end
        if (wr_hit[2]) begin
            next_st.lane_c = lane_write(st.lane_c, mask, mgmt_req.wdata);
        end
        if (wr_hit[3]) begin
            next_st.lane_ch = lane_write(st.lane_ch, mask, mgmt_req.wdata);
        end
        // Reads see the state before a same-cycle write
        next_st.rsp.rvalid = mgmt_req.rd;
        if (mgmt_req.rd) begin
            next_st.rsp.rdata = `LSP_RDATA_NONE;
        end
        if (rd_hit[0]) begin
            next_st.rsp.rdata = st.ctrl;
        end
        if (rd_hit[1]) begin
            next_st.rsp.rdata = lane_read(st.lane_b, sel);
        end
        if (rd_hit[2]) begin
            next_st.rsp.rdata = lane_read(st.lane_c, sel);
        end
        if (rd_hit[3]) begin
            next_st.rsp.rdata = lane_read(st.lane_ch, sel);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    assign mgmt_rsp = st.rsp;
    assign pll_run = st.pll_run;
    assign pll_loop_bw_sel = st.ctrl.pll_loop_bw_sel;
    assign pll_multiplier = st.ctrl.pll_multiplier;
    assign lane_ctrl_b = st.lane_b;
    assign lane_ctrl_c = st.lane_c;
    assign lane_channel_ctrl = st.lane_ch;

endmodule // lsp_lane_pll_ctrl
`default_nettype wire

// File: lsp_host.sv
// Management host model issuing single register transfers
`default_nettype none
module lsp_host (
    // Clock
    input wire logic clk,
    // Register port
    output var lsp_pkg::lsp_req_t req,
    input wire lsp_pkg::lsp_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = '0;
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic v);
        @(posedge clk);
        req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        req <= '0;
        // Answer stands in the cycle after the taking edge; look mid-cycle
        @(negedge clk);
        q = rsp.rdata;
        v = rsp.rvalid;
    endtask
endmodule // lsp_host
`default_nettype wire

// File: lsp_lane_pll_ctrl_properties.sv
// Timing properties of the lane-select and PLL control bank
`default_nettype none
module lsp_lane_pll_ctrl_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire lsp_pkg::lsp_req_t mgmt_req,
    input wire lsp_pkg::lsp_rsp_t mgmt_rsp,
    // Power and outputs
    input wire logic channel_powerdown_n,
    input wire logic global_powerdown,
    input wire logic pll_run,
    input wire logic [1:0] pll_loop_bw_sel,
    input wire logic [3:0] pll_multiplier,
    input wire lsp_pkg::lsp_lanes_t lane_ctrl_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic [3:0] mask;
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst) mask <= 4'hF;
        else if (mgmt_req.wr && mgmt_req.addr == 16'h0006) mask <= mgmt_req.wdata[15:12];
    sequence s_ctrl_wr;
        mgmt_req.wr && mgmt_req.addr == 16'h0006;
    endsequence
    sequence s_lane_wr;
        mgmt_req.wr && mgmt_req.addr == 16'h0007;
    endsequence
    sequence s_lane_rd;
        mgmt_req.rd && mgmt_req.addr == 16'h0007 && mask == 4'h4;
    endsequence
    a_global_off: assert property (global_powerdown |=> !pll_run)
        else $error("pll runs during global power-down");
    a_pin_off: assert property (!channel_powerdown_n |-> ##3 !pll_run)
        else $error("pll runs during pin power-down");
    a_pll_gate: assert property (s_ctrl_wr ##0 !mgmt_req.wdata[4] |-> ##2 !pll_run)
        else $error("pll runs with enable cleared");
    a_mpy_follow: assert property (s_ctrl_wr |=> pll_multiplier == $past(mgmt_req.wdata[3:0]))
        else $error("multiplier not updated");
    a_bw_follow: assert property (s_ctrl_wr |=> pll_loop_bw_sel == $past(mgmt_req.wdata[9:8]))
        else $error("loop bandwidth not updated");
    for (genvar n = 0; n < 4; n++) begin : g_lane
        a_lane_write: assert property (s_lane_wr |=> lane_ctrl_b[n] ==
            ($past(mask[n]) ? $past(mgmt_req.wdata) : $past(lane_ctrl_b[n])))
            else $error("lane write ignores mask");
    end
    a_lane_read: assert property (s_lane_rd |=> mgmt_rsp.rdata == $past(lane_ctrl_b[2]))
        else $error("lane read wrong lane");
    a_valid_pulse: assert property (mgmt_rsp.rvalid == $past(mgmt_req.rd))
        else $error("read answer timing wrong");
endmodule // lsp_lane_pll_ctrl_properties
`default_nettype wire

// File: lsp_lane_pll_ctrl_bench.sv
// Testbench for the lane-select and PLL control bank
`default_nettype none
module lsp_lane_pll_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic channel_powerdown_n = 1'b1;
    logic global_powerdown = 1'b0;
    lsp_pkg::lsp_req_t req;
    lsp_pkg::lsp_rsp_t rsp;
    logic pll_run;
    logic [1:0] bw;
    logic [3:0] mpy;
    logic [15:0] q;
    logic v;
    lsp_pkg::lsp_lanes_t lc_b;
    lsp_pkg::lsp_lanes_t lc_c;
    lsp_pkg::lsp_lanes_t lc_ch;
    int n_fail = 0;
    int n_tests = 0;
    always #2.5 clk = ~clk;
    lsp_host host (.clk(clk), .req(req), .rsp(rsp));
    lsp_lane_pll_ctrl dut (.clk(clk), .sys_rst(sys_rst), .mgmt_req(req), .mgmt_rsp(rsp),
        .channel_powerdown_n(channel_powerdown_n), .global_powerdown(global_powerdown),
        .pll_run(pll_run), .pll_loop_bw_sel(bw), .pll_multiplier(mpy), .lane_ctrl_b(lc_b),
        .lane_ctrl_c(lc_c), .lane_channel_ctrl(lc_ch));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        host.xfer(1'b1, a, d, q, v);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        host.xfer(1'b0, a, 16'h0000, q, v);
        check({15'h0, v}, 16'h0001);
        check(q, exp);
    endtask
    task automatic t_reset;
        rd(16'h0006, 16'hF115);
        check({14'h0, bw}, 16'h0001);
        check({12'h0, mpy}, 16'h0005);
        check({15'h0, pll_run}, 16'h0001);
        $display("test reset done");
    endtask
    task automatic t_lanes;
        wr(16'h0006, 16'h3115);
        wr(16'h0007, 16'hA5A5);
        check(lc_b[1], 16'hA5A5);
        check(lc_b[2], 16'hDC04);
        wr(16'h0006, 16'h0115);
        wr(16'h0008, 16'h1234);
        check(lc_c[3], 16'h0000);
        wr(16'h0006, 16'h1115);
        rd(16'h0007, 16'hA5A5);
        wr(16'h0006, 16'h4115);
        rd(16'h0007, 16'hDC04);
        wr(16'h0006, 16'h8115);
        rd(16'h0008, 16'h0000);
        rd(16'h0020, 16'h0000);
        wr(16'h0006, 16'hC115);
        wr(16'h0010, 16'hBEEF);
        check(lc_ch[3], 16'hBEEF);
        check(lc_ch[1], 16'h0000);
        rd(16'h0010, 16'h0000);
        wr(16'h0006, 16'h8115);
        rd(16'h0010, 16'hBEEF);
        $display("test lanes done");
    endtask
    task automatic t_fields;
        wr(16'h0006, 16'h4EEE);
        rd(16'h0006, 16'h4EEE);
        check({12'h0, mpy}, 16'h000E);
        check({15'h0, pll_run}, 16'h0000);
        wr(16'h0006, 16'hF115);
        repeat (2) @(negedge clk);
        check({15'h0, pll_run}, 16'h0001);
        @(posedge clk);
        global_powerdown <= 1'b1;
        repeat (3) @(negedge clk);
        check({15'h0, pll_run}, 16'h0000);
        @(posedge clk);
        global_powerdown <= 1'b0;
        channel_powerdown_n <= 1'b0;
        repeat (5) @(negedge clk);
        check({15'h0, pll_run}, 16'h0000);
        @(posedge clk);
        channel_powerdown_n <= 1'b1;
        repeat (5) @(negedge clk);
        check({15'h0, pll_run}, 16'h0001);
        $display("test fields done");
    endtask
    task automatic t_rst_mid;
        wr(16'h0006, 16'h2A27);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        rd(16'h0006, 16'hF115);
        check({15'h0, pll_run}, 16'h0001);
        $display("test mid-run reset done");
    endtask
    task automatic finish_test;
        $display("tests=%0d mismatches=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_reset;
        t_lanes;
        t_fields;
        t_rst_mid;
        finish_test;
    end
    initial begin
        #5000;
        n_fail++;
        finish_test;
    end
endmodule // lsp_lane_pll_ctrl_bench
bind lsp_lane_pll_ctrl lsp_lane_pll_ctrl_properties chk (.clk(clk), .sys_rst(sys_rst),
    .mgmt_req(mgmt_req), .mgmt_rsp(mgmt_rsp), .channel_powerdown_n(channel_powerdown_n),
    .global_powerdown(global_powerdown), .pll_run(pll_run), .pll_loop_bw_sel(pll_loop_bw_sel),
    .pll_multiplier(pll_multiplier), .lane_ctrl_b(lane_ctrl_b));
`default_nettype wire
